//--- lra_correlator.sv
// Sine excitation generator and response correlator
//
// Summary of operation
// - One sine period held in read-only table
// - Step is table length times frequency ratio
// - Each tick adds step, looks up sample
// - Index wraps by dropping overflow bits
// - Fractional phase kept, integer part addresses
// - Quadrature read at quarter-table offset
// - Multiply response by cos, sin; accumulate
// - Same sequences serve injection and reference
// - Interval length cycles times rate over frequency
// - Inject at filter output, sample error converter
// - Two result words kept after interval
`include "lra_regs.svh"
module lra_correlator #(
	parameter int TBITS = `LRA_TABLE_BITS,
	parameter int FBITS = `LRA_FRAC_BITS,
	parameter int SBITS = `LRA_SAMPLE_BITS,
	parameter int ABITS = `LRA_AMP_BITS,
	parameter int CBITS = `LRA_COUNT_BITS,
	parameter int ACCB = `LRA_ACC_BITS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sample_tick,
	input wire logic start,
	input wire logic enable,
	input wire logic [TBITS+FBITS-1:0] phase_step,
	input wire logic [CBITS-1:0] interval_len,
	input wire logic [ABITS-1:0] amplitude,
	input wire logic signed [SBITS-1:0] filter_out,
	input wire logic signed [SBITS-1:0] error_adc,
	output logic signed [SBITS-1:0] drive_out_reg,
	output logic signed [ACCB-1:0] real_result_reg,
	output logic signed [ACCB-1:0] imag_result_reg,
	output logic busy_reg,
	output logic done_reg
);
	localparam int PBITS = TBITS + FBITS;
	localparam int PRODB = SBITS + ABITS;
	localparam int EXB = ABITS + ABITS + 1;

	lra_pkg::lra_state_t state_reg;
	logic [PBITS-1:0] phase_reg;
	logic [CBITS-1:0] count_reg;
	logic signed [ACCB-1:0] acc_re_reg;
	logic signed [ACCB-1:0] acc_im_reg;
	logic tick_d_reg;
	logic first_reg;
	logic [TBITS-1:0] sin_addr;
	logic [TBITS-1:0] cos_addr;
	logic signed [ABITS-1:0] sin_val;
	logic signed [ABITS-1:0] cos_val;
	logic signed [ABITS+ABITS:0] exc_scaled;
	logic signed [SBITS:0] drive_sum;
	logic signed [SBITS-1:0] drive_next;
	logic signed [PRODB-1:0] prod_re;
	logic signed [PRODB-1:0] prod_im;

	// ==========================================================
	// Phase accumulator
	// ==========================================================
	// Step is computed by host as N_table*F_meas/F_s in fixed point
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase_reg <= '0;
		end else if (start) begin
			phase_reg <= '0;
		end else if (sample_tick && state_reg == lra_pkg::LRA_RUN) begin
			phase_reg <= phase_reg + phase_step;
		end
	end

	// Integer part only; truncation of the fraction
	assign sin_addr = phase_reg[PBITS-1:FBITS];
	assign cos_addr = sin_addr + TBITS'(`LRA_QUARTER);

	// One table feeds both injection and correlation
	lra_sine_rom #(
		.ABITS(TBITS),
		.DBITS(ABITS)
	) u_rom (
		.clk(clk),
		.addr_a(sin_addr),
		.addr_b(cos_addr),
		.data_a(sin_val),
		.data_b(cos_val)
	);

	// ==========================================================
	// Excitation injection
	// ==========================================================
	assign exc_scaled = EXB'(sin_val) * EXB'($signed({1'b0, amplitude}));
	assign drive_sum = (SBITS+1)'(filter_out) + (SBITS+1)'($signed(exc_scaled[ABITS+ABITS-1:ABITS+ABITS-SBITS]));

	// Saturate so the injected sum never wraps
	always_comb begin
		if (state_reg != lra_pkg::LRA_RUN) begin
			drive_next = filter_out;
		end else if (drive_sum[SBITS] != drive_sum[SBITS-1]) begin
			drive_next = drive_sum[SBITS] ? {1'b1, {(SBITS-1){1'b0}}} : {1'b0, {(SBITS-1){1'b1}}};
		end else begin
			drive_next = drive_sum[SBITS-1:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			drive_out_reg <= '0;
		end else begin
			drive_out_reg <= drive_next;
		end
	end

	// ==========================================================
	// Correlation
	// ==========================================================
	// Products use table values, independent of amplitude setting
	assign prod_re = PRODB'(error_adc) * PRODB'(cos_val);
	assign prod_im = PRODB'(error_adc) * PRODB'(sin_val);

	// ROM is registered, so accumulate one clock after the tick
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick_d_reg <= 1'b0;
		end else begin
			tick_d_reg <= sample_tick && state_reg == lra_pkg::LRA_RUN;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_re_reg <= '0;
			acc_im_reg <= '0;
		end else if (start) begin
			acc_re_reg <= '0;
			acc_im_reg <= '0;
		end else if (tick_d_reg && first_reg) begin
			acc_re_reg <= ACCB'(prod_re);
			acc_im_reg <= ACCB'(prod_im);
		end else if (tick_d_reg) begin
			acc_re_reg <= acc_re_reg + ACCB'(prod_re);
			acc_im_reg <= acc_im_reg + ACCB'(prod_im);
		end
	end

	// First product after start; the table lags the phase by a tick
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			first_reg <= 1'b0;
		end else if (start) begin
			first_reg <= 1'b1;
		end else if (tick_d_reg) begin
			first_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Interval control
	// ==========================================================
	// Interval length = round(k*Fs/F_meas), precomputed by host
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= lra_pkg::LRA_IDLE;
			count_reg <= '0;
		end else if (start) begin
			// Refused start must not fall back into a stale done state
			state_reg <= enable ? lra_pkg::LRA_RUN : lra_pkg::LRA_IDLE;
			count_reg <= '0;
		end else begin
			case (state_reg)
				lra_pkg::LRA_IDLE: begin
					state_reg <= lra_pkg::LRA_IDLE;
				end
				lra_pkg::LRA_RUN: begin
					if (!enable) begin
						state_reg <= lra_pkg::LRA_IDLE;
					end else if (sample_tick) begin
						count_reg <= count_reg + CBITS'(1);
						if (count_reg + CBITS'(1) >= interval_len) begin
							state_reg <= lra_pkg::LRA_DONE;
						end
					end
				end
				lra_pkg::LRA_DONE: begin
					state_reg <= lra_pkg::LRA_DONE;
				end
				default: begin
					state_reg <= lra_pkg::LRA_IDLE;
				end
			endcase
		end
	end

	// Results latched once the last product has been summed
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			real_result_reg <= '0;
			imag_result_reg <= '0;
			done_reg <= 1'b0;
		end else if (start) begin
			real_result_reg <= '0;
			imag_result_reg <= '0;
			done_reg <= 1'b0;
		end else if (state_reg == lra_pkg::LRA_DONE && !done_reg && !tick_d_reg) begin
			real_result_reg <= acc_re_reg;
			imag_result_reg <= acc_im_reg;
			done_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= state_reg == lra_pkg::LRA_RUN;
		end
	end
endmodule

//--- lra_regs.svh
// Constants for the loop response analysis correlator
`ifndef LRA_REGS_SVH
`define LRA_REGS_SVH
`define LRA_TABLE_BITS 8
`define LRA_FRAC_BITS 16
`define LRA_SAMPLE_BITS 12
`define LRA_AMP_BITS 12
`define LRA_ACC_BITS 56
`define LRA_COUNT_BITS 24
`define LRA_QUARTER 8'h40
`endif

//--- lra_pkg.sv
// Types for the loop response analysis correlator
package lra_pkg;
	typedef enum logic [1:0] {
		LRA_IDLE = 2'b00,
		LRA_RUN = 2'b01,
		LRA_DONE = 2'b11
	} lra_state_t;
endpackage

//--- lra_sine_rom.sv
// One-period sine lookup table, two read ports
`include "lra_regs.svh"
module lra_sine_rom #(
	parameter int ABITS = `LRA_TABLE_BITS,
	parameter int DBITS = `LRA_AMP_BITS
) (
	input wire logic clk,
	input wire logic [ABITS-1:0] addr_a,
	input wire logic [ABITS-1:0] addr_b,
	output logic signed [DBITS-1:0] data_a,
	output logic signed [DBITS-1:0] data_b
);
	localparam int DEPTH = 1 << ABITS;
	localparam real PI = 3.14159265358979;
	logic signed [DBITS-1:0] rom [DEPTH];
	// Constant contents built at elaboration
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_tab
			assign rom[i] = DBITS'($rtoi($sin(2.0 * PI * i / DEPTH) * ((1 << (DBITS - 1)) - 1)));
		end
	endgenerate
	always_ff @(posedge clk) begin
		data_a <= rom[addr_a];
		data_b <= rom[addr_b];
	end
endmodule

//--- lra_monitor.sv
// Port checker for the correlator
module lra_monitor #(parameter int SBITS = 12, parameter int ACCB = 56) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic enable,
	input wire logic signed [SBITS-1:0] filter_out,
	input wire logic signed [SBITS-1:0] drive_out_reg,
	input wire logic signed [ACCB-1:0] real_result_reg,
	input wire logic signed [ACCB-1:0] imag_result_reg,
	input wire logic busy_reg,
	input wire logic done_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========
	// Properties
	AST_GO: assert property (start && enable |-> ##2 busy_reg)
		else $error("no run");
	AST_CLR: assert property (start |=> !done_reg && real_result_reg == 0 && imag_result_reg == 0)
		else $error("no clear");
	AST_REFUSE: assert property (start && !enable |-> ##2 (!busy_reg && !done_reg))
		else $error("ran disabled");
	AST_HOLD: assert property (done_reg && !start |=> done_reg)
		else $error("done lost");
	AST_FROZEN: assert property (done_reg && !start |=> $stable(real_result_reg) && $stable(imag_result_reg))
		else $error("result moved");
	AST_AFTER_RUN: assert property ($rose(done_reg) |-> $past(busy_reg) || $past(busy_reg, 2))
		else $error("done without run");
	AST_ABORT: assert property (busy_reg && !enable && !start |-> ##[1:3] (!busy_reg && !done_reg))
		else $error("no abort");
	AST_PASS: assert property ($past(nrst) && !busy_reg && !$past(busy_reg) |-> drive_out_reg == $past(filter_out))
		else $error("idle drive");
	cover property ($rose(done_reg));
	cover property (busy_reg && !enable);
	cover property (start && !enable);
endmodule

//--- lra_partner.sv
// Compensator and error converter stand-in
module lra_partner (
	input wire logic clk,
	output logic sample_tick = 1'b0,
	output logic signed [11:0] filter_out = 12'sh000,
	output logic signed [11:0] error_adc = 12'sh000
);
	timeunit 1ns;
	timeprecision 1ps;
	logic signed [11:0] resp [8];
	// ==========
	// Sample frames
	task automatic frame(input int gap, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk) sample_tick <= 1'b1;
			@(posedge clk) sample_tick <= 1'b0;
			error_adc <= resp[i];
			filter_out <= resp[i] >>> 1;
			// Hold time over: show garbage, not the old sample
			@(posedge clk) error_adc <= ~resp[i];
			repeat (gap) @(posedge clk);
		end
	endtask
endmodule

//--- lra_correlator_test.sv
// Self-checking bench for the correlator
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; $display("ERROR %0t: mismatch", $time); end end
module lra_correlator_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, start, enable, sample_tick, busy_reg, done_reg;
	logic [23:0] phase_step, interval_len;
	logic [11:0] amplitude;
	logic signed [11:0] filter_out, error_adc, drive_out_reg;
	logic signed [55:0] real_result_reg, imag_result_reg;
	int fails = 0;
	int tests_run = 0;
	lra_correlator dut (.clk, .nrst, .sample_tick, .start, .enable, .phase_step, .interval_len, .amplitude,
		.filter_out, .error_adc, .drive_out_reg, .real_result_reg, .imag_result_reg, .busy_reg, .done_reg);
	lra_partner p (.clk, .sample_tick, .filter_out, .error_adc);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic stop_test;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========
	// Scenarios
	task automatic go(input logic en, input logic [23:0] st, input logic [23:0] len);
		@(posedge clk);
		start <= 1'b1;
		enable <= en;
		phase_step <= st;
		interval_len <= len;
		@(posedge clk);
		start <= 1'b0;
	endtask
	task automatic measure(input logic [23:0] st, input logic [23:0] len, input int gap,
		input logic signed [55:0] er, input logic signed [55:0] ei);
		go(1'b1, st, len);
		p.frame(gap, (len == 24'h0) ? 1 : int'(len));
		for (int k = 0; k < 9 && done_reg !== 1'b1; k++)
			@(negedge clk);
		if (done_reg !== 1'b1) begin
			fails++;
			$display("ERROR %0t: no done", $time);
			stop_test();
		end
		`CHK(real_result_reg, er)
		`CHK(imag_result_reg, ei)
		$display("measure %h/%0d finished", st, len);
	endtask
	task automatic refuse;
		go(1'b0, 24'h400000, 24'h4);
		repeat (3) @(negedge clk);
		`CHK(done_reg, 1'b0)
		`CHK(real_result_reg, 56'sh0)
		$display("refused start finished");
	endtask
	task automatic abort;
		go(1'b1, 24'h400000, 24'h7);
		p.frame(0, 2);
		enable <= 1'b0;
		repeat (5) @(negedge clk);
		`CHK(busy_reg, 1'b0)
		`CHK(done_reg, 1'b0)
		$display("abort finished");
	endtask
	task automatic inject;
		go(1'b1, 24'h400000, 24'h8);
		p.frame(0, 1);
		repeat (2) @(negedge clk);
		`CHK(drive_out_reg, 12'sh431)
		@(posedge clk);
		amplitude <= 12'hfff;
		repeat (2) @(negedge clk);
		`CHK(drive_out_reg, 12'sh7ff)
		@(posedge clk);
		enable <= 1'b0;
		amplitude <= 12'h7ff;
		repeat (3) @(negedge clk);
		`CHK(drive_out_reg, 12'sh032)
		$display("inject finished");
	endtask
	initial begin
		nrst = 1'b0;
		start = 1'b0;
		enable = 1'b0;
		phase_step = 24'h0;
		interval_len = 24'h0;
		amplitude = 12'h7ff;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		p.resp = '{12'sh064, -12'sh032, 12'sh01e, 12'sh007, 12'sh0, 12'sh0, 12'sh0, 12'sh0};
		measure(24'h400000, 24'h4, 0, 56'sh22fba, -56'sh1c7c7);
		// Fractional step lands on 128 and wraps to 0 only if the fraction is kept
		p.resp = '{12'sh064, 12'sh0, 12'sh0, -12'sh01e, 12'sh0, 12'sh0, 12'sh005, 12'sh0};
		measure(24'h2aaaab, 24'h7, 5, 56'sh43779, 56'sh0);
		// Zero interval length still takes one sample, then done
		measure(24'h400000, 24'h0, 0, 56'sh31f9c, 56'sh0);
		refuse();
		abort();
		inject();
		stop_test();
	end
endmodule
bind lra_correlator lra_monitor #(.SBITS(SBITS), .ACCB(ACCB)) mon (.clk, .nrst, .start, .enable, .filter_out,
	.drive_out_reg, .real_result_reg, .imag_result_reg, .busy_reg, .done_reg);
